//--- logic/eil_pkg.sv
// Package: register map, fields and reset values of the external interrupt latch
//
// Notes on behaviour
// - A qualifying low event on the pin sets the request latch until cleared.
// - A vector fetch for this interrupt acknowledges and clears the latch.
// - Writing one to the acknowledge bit acknowledges and clears the latch.
// - Reset clears latch, sensitivity, mask and acknowledge bits, even with pin low.
// - Edge mode: only falling edges set; any acknowledge clears at once.
// - Level mode: request clears after acknowledge and pin high, either order.
// - Level mode: request stays pending while the pin is held low.
// - Mask bit one withholds the request from priority logic; latch keeps working.
// - Pending flag reads the pending state, independent of the mask.
// - Acknowledge bit is write-only, reads zero, stores nothing.
// - Sensitivity bit read/write: one edge and level, zero edge only.
// - A falling edge after a software acknowledge latches a new request.
// - Serviced request loads the program counter from vector at FFFA/FFFB.
// - Break clear enable one: acknowledge in break clears, stays cleared after.
// - Break clear enable zero: software acknowledge in break leaves latch unchanged.
// - The current pin level is given to the CPU for branch tests.
package eil_pkg;
  localparam logic [11:0] EIL_STATUS_CONTROL_OFF = 12'h000;
  localparam logic [11:0] EIL_BREAK_CONTROL_OFF  = 12'h004;
  localparam int          EIL_MODE_BIT           = 0;
  localparam int          EIL_MASK_BIT           = 1;
  localparam int          EIL_ACK_BIT            = 2;
  localparam int          EIL_PEND_BIT           = 3;
  localparam int          EIL_BREAK_CLEAR_ENABLE_BIT           = 7;
  localparam logic        EIL_MODE_RST           = 1'b0;
  localparam logic        EIL_MASK_RST           = 1'b0;
  localparam logic        EIL_BREAK_CLEAR_ENABLE_RST           = 1'b0;
  localparam logic [15:0] EIL_VECTOR_HI_ADDR     = 16'hFFFA;
  localparam logic [15:0] EIL_VECTOR_LO_ADDR     = 16'hFFFB;
  typedef enum logic [1:0] {
    EIL_EDGE_ONLY  = 2'b01,
    EIL_EDGE_LEVEL = 2'b10
  } eil_sense_t;
endpackage

//--- logic/eil_sync.sv
// Two-flop synchroniser with previous-sample register for edge detection
`timescale 1ns/1ps
module eil_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      sync_q,
  output logic      prev_q
);
  logic meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
endmodule

//--- logic/eil_apb.sv
// APB slave decode for the two control registers
`timescale 1ns/1ps
module eil_apb (
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  output logic             wr_sc,
  output logic             wr_brk,
  output logic             rd_sc,
  output logic             rd_brk,
  output logic             pready,
  output logic             pslverr
);
  import eil_pkg::*;
  wire access_w = psel & penable;
  wire hit_sc   = (paddr == EIL_STATUS_CONTROL_OFF);
  wire hit_brk  = (paddr == EIL_BREAK_CONTROL_OFF);

  assign pready  = 1'b1;
  assign wr_sc   = access_w & pwrite & hit_sc;
  assign wr_brk  = access_w & pwrite & hit_brk;
  assign rd_sc   = hit_sc;
  assign rd_brk  = hit_brk;
  assign pslverr = access_w & ~(hit_sc | hit_brk);
endmodule

//--- logic/eil_top.sv
// External interrupt latch: pin capture, acknowledge, mask, APB registers
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module eil_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        irq_pin_n,
  input  wire logic        vector_fetch,
  input  wire logic        break_state,
  output logic             irq_request,
  output logic [15:0]      irq_vector_addr,
  output logic             irq_pin_level
);
  import eil_pkg::*;

  ////////////////////////////////////////////////////////////////
  logic        pin_q;
  logic        pin_prev_q;
  logic        wr_sc;
  logic        wr_brk;
  logic        rd_sc;
  logic        rd_brk;
  logic        latch_q;
  logic        latch_d;
  logic        mask_q;
  logic        break_clear_enable_q;
  logic        ack_seen_q;
  eil_sense_t  sense_q;
  logic [31:0] rdata_d;

  eil_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (irq_pin_n),
    .sync_q  (pin_q),
    .prev_q  (pin_prev_q)
  );

  eil_apb u_apb (
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .wr_sc   (wr_sc),
    .wr_brk  (wr_brk),
    .rd_sc   (rd_sc),
    .rd_brk  (rd_brk),
    .pready  (pready),
    .pslverr (pslverr)
  );

  ////////////////////////////////////////////////////////////////
  wire level_mode = (sense_q == EIL_EDGE_LEVEL);
  wire fall_edge  = pin_prev_q & ~pin_q;
  wire sw_ack_raw = wr_sc & pwdata[EIL_ACK_BIT];
  wire sw_ack     = sw_ack_raw & (~break_state | break_clear_enable_q);
  wire ack        = sw_ack | vector_fetch;
  // Level mode clears only once the pin is high as well; a remembered ack counts
  wire clr_ok     = (ack | ack_seen_q) & (~level_mode | pin_q);
  wire pending    = latch_q | (level_mode & ~pin_q & ack_seen_q);

  // Set beats clear: a new edge in the acknowledge cycle is kept
  assign latch_d = fall_edge ? 1'b1 : (clr_ok ? 1'b0 : latch_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_q <= 1'b0;
    end else begin
      latch_q <= latch_d;
    end
  end

  // Acknowledge seen in level mode while pin low; clear at pin high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_seen_q <= 1'b0;
    end else if (!level_mode || pin_q || fall_edge) begin
      ack_seen_q <= 1'b0;
    end else if (ack && latch_q) begin
      ack_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q  <= EIL_MASK_RST;
      sense_q <= EIL_EDGE_ONLY;
      break_clear_enable_q  <= EIL_BREAK_CLEAR_ENABLE_RST;
    end else begin
      if (wr_sc) begin
        mask_q  <= pwdata[EIL_MASK_BIT];
        sense_q <= pwdata[EIL_MODE_BIT] ? EIL_EDGE_LEVEL : EIL_EDGE_ONLY;
      end
      if (wr_brk) begin
        break_clear_enable_q <= pwdata[EIL_BREAK_CLEAR_ENABLE_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data: acknowledge bit always zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (rd_sc) begin
      rdata_d[EIL_PEND_BIT] = pending;
      rdata_d[EIL_MASK_BIT] = mask_q;
      rdata_d[EIL_MODE_BIT] = level_mode;
    end else if (rd_brk) begin
      rdata_d[EIL_BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata          <= 32'h0000_0000;
      irq_request     <= 1'b0;
      irq_pin_level   <= 1'b1;
      irq_vector_addr <= EIL_VECTOR_HI_ADDR;
    end else begin
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_d;
      end
      irq_request     <= latch_d & ~mask_q;
      irq_pin_level   <= pin_q;
      irq_vector_addr <= EIL_VECTOR_HI_ADDR;
    end
  end

  ////////////////////////////////////////////////////////////////
  a_reset_clears: assert property (@(posedge pclk) $rose(presetn) |-> !latch_q)
    else $error("latch not clear after reset");

  a_edge_sets_latch: assert property (@(posedge pclk) disable iff (!presetn)
    fall_edge |=> latch_q)
    else $error("falling edge not latched");

  a_edge_ack_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (!level_mode && ack && !fall_edge) |=> !latch_q)
    else $error("edge mode acknowledge did not clear");

  a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (level_mode && latch_q && !pin_q) |=> latch_q)
    else $error("level mode request dropped while pin low");

  sequence s_ack_low;
    level_mode && latch_q && ack && !pin_q;
  endsequence
  a_level_pair: assert property (@(posedge pclk) disable iff (!presetn)
    s_ack_low ##1 (pin_q && level_mode && !fall_edge) |=> !latch_q)
    else $error("level mode not cleared after ack and pin high");

  a_mask_blocks: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(mask_q) && !$past(wr_sc)) |-> !irq_request)
    else $error("masked request reached priority logic");

  a_unmasked_passes: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_q && !mask_q && !wr_sc && !clr_ok) |=> irq_request)
    else $error("unmasked request withheld");

  a_break_protect: assert property (@(posedge pclk) disable iff (!presetn)
    (latch_q && break_state && !break_clear_enable_q && !vector_fetch) |=> latch_q)
    else $error("break state acknowledge cleared latch");

  a_ack_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !rdata_d[EIL_ACK_BIT])
    else $error("acknowledge bit read nonzero");

  a_pin_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 (irq_pin_level == $past(pin_q)))
    else $error("pin level output wrong");
endmodule

//--- bench/eil_cpu_model.sv
// Partner model: CPU interrupt logic that fetches the vector on request
`timescale 1ns/1ps
module eil_cpu_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        irq_request,
  input  wire logic [15:0] irq_vector_addr,
  input  wire logic        glob_mask,
  input  wire logic [3:0]  delay,
  output logic             vector_fetch
);
  import eil_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] wait_q;
  // Fetch after a chosen latency, then hold off for eight cycles before looking again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q        <= 4'h0;
      wait_q       <= 4'h0;
      vector_fetch <= 1'b0;
    end else begin
      vector_fetch <= 1'b0;
      if (cnt_q != 4'h0) begin
        cnt_q <= cnt_q - 4'h1;
      end else if (irq_request && !glob_mask && irq_vector_addr == EIL_VECTOR_HI_ADDR) begin
        if (wait_q == delay) begin
          vector_fetch <= 1'b1;
          cnt_q        <= 4'h8;
          wait_q       <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule

//--- bench/external_interrupt_latch_test.sv
// Self-checking testbench of the external interrupt latch
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; $display("FAIL %0t mismatch %0h %0h", $time, a, b); end end
module external_interrupt_latch_test;
  import eil_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        irq_pin_n = 1, break_state = 0, glob_mask = 1;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic        pready, pslverr, err, irq_request, irq_pin_level, vector_fetch;
  logic [15:0] irq_vector_addr;
  logic [3:0]  delay = 0;
  int          num_errors = 0, total_checks = 0, lat = 0, mode = 0, mask = 0, break_clear_enable = 0, ackd = 0, pin = 1;
  eil_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .irq_pin_n, .vector_fetch, .break_state, .irq_request, .irq_vector_addr,
    .irq_pin_level);
  eil_cpu_model cpu_u (.pclk, .presetn, .irq_request, .irq_vector_addr, .glob_mask, .delay,
    .vector_fetch);
  always #5 pclk = ~pclk;
  ////////////////////////////////////////////////////////////////////////////
  task apb(input logic [11:0] a, input logic w, input logic [31:0] v);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task ack;
    apb(EIL_STATUS_CONTROL_OFF, 1'b1, 32'(mask * 2 + mode + 4));
    if (!break_state || break_clear_enable) begin
      if (!mode) lat = 0; else ackd = 1;
    end
    if (mode && ackd && pin) lat = 0;
    repeat (3) @(posedge pclk);
  endtask
  task setp(input int v);
    irq_pin_n <= v[0];
    if (!v && pin) begin lat = 1; ackd = 0; end
    if (v && mode && ackd) lat = 0;
    pin = v;
    repeat (6) @(posedge pclk);
  endtask
  task setm(input logic [31:0] v);
    mode = v[0]; mask = v[1];
    apb(EIL_STATUS_CONTROL_OFF, 1'b1, v & 32'hFFFFFFFB);
  endtask
  task setb(input int b);
    break_clear_enable = b;
    apb(EIL_BREAK_CONTROL_OFF, 1'b1, 32'(b * 128));
    apb(EIL_BREAK_CONTROL_OFF, 1'b0, 32'h0);
    `CHK(rd, 32'(break_clear_enable * 128))
  endtask
  task chk;
    apb(EIL_STATUS_CONTROL_OFF, 1'b0, 32'h0);
    `CHK(rd, 32'(lat * 8 + mask * 2 + mode))
    `CHK(irq_request, 1'(lat && !mask))
    `CHK(irq_pin_level, 1'(pin))
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h93e2b486));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk;
    apb(12'h008, 1'b0, 32'h0);
    `CHK(err, 1'b1)
    `CHK(pready, 1'b1)
    `CHK(irq_vector_addr, EIL_VECTOR_HI_ADDR)
    setb(0);
    $display("test reset done");
    setp(0); chk; ack; chk; setp(1); setp(0); chk; ack; chk; setp(1);
    setm(2); setp(0); chk; ack; setp(1); setm(0); chk;
    $display("test edge done");
    setm(1); setp(0); ack; chk; setp(1); chk; setp(0); setp(1); chk; ack; chk;
    $display("test level done");
    setm(0); setp(0); break_state <= 1'b1; ack; chk; setb(1); ack; chk;
    break_state <= 1'b0; setb(0); chk; setp(1);
    $display("test break done");
    for (int i = 0; i < 2; i++) begin
      delay <= 4'(i * 9);
      setp(0);
      `CHK(irq_request, 1'b1)
      glob_mask <= 1'b0;
      repeat (20) @(posedge pclk);
      glob_mask <= 1'b1;
      lat = 0;
      chk;
      setp(1);
    end
    $display("test vector done");
    repeat (4) begin d = $urandom; setm(d); chk; end
    setm(3); setp(0);
    presetn <= 1'b0;
    @(posedge pclk);
    `CHK(irq_request, 1'b0)
    irq_pin_n <= 1'b1; pin = 1;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    lat = 0; mode = 0; mask = 0; ackd = 0;
    chk; setb(0);
    $display("test second reset done");
    give_verdict;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    num_errors++;
    $display("FAIL %0t timeout", $time);
    give_verdict;
  end
endmodule
